//--- verification/area3_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module area3_chk
  import area3_wait_pkg::*;
#(
  parameter int LANES = 4
) (
  input wire logic             core_clk_i,
  input wire logic             reset_i,
  input wire logic [7:0]       reg_addr_i,
  input wire logic [31:0]      reg_wdata_i,
  input wire logic             reg_write_i,
  input wire logic             reg_read_i,
  input wire logic [31:0]      reg_rdata_o,
  input wire logic             access_req_i,
  input wire logic             access_busy_o,
  input wire logic             access_done_o,
  input wire logic             ext_wait_n_i,
  input wire logic [LANES-1:0] access_lanes_i,
  input wire logic [LANES-1:0] byte_enable_n_o,
  input wire logic             rd_wr_n_o
);
  logic             bas_reg;   // Shadow of byte access select
  logic             mask_reg;  // Shadow of wait mask
  logic [3:0]       code_reg;  // Shadow of read wait code
  logic [LANES-1:0] lanes_reg; // Lanes of the running access
  logic [4:0]       cnt_reg;   // Busy cycles so far
  // Shadow state; the bench never rewrites the word mid-access
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bas_reg <= BYTE_ACCESS_SELECT_RST;
      mask_reg <= EXT_WAIT_MASK_RST;
      code_reg <= READ_WAIT_RST;
      lanes_reg <= '0;
      cnt_reg <= 5'h00;
    end else begin
      if (reg_write_i && reg_addr_i == AREA3_WAIT_CONTROL_OFF) begin
        bas_reg <= reg_wdata_i[BYTE_ACCESS_SELECT_BIT];
        mask_reg <= reg_wdata_i[EXT_WAIT_MASK_BIT];
        code_reg <= reg_wdata_i[READ_WAIT_MSB:READ_WAIT_LSB];
      end
      if (access_req_i && !access_busy_o) lanes_reg <= access_lanes_i;
      cnt_reg <= access_busy_o ? cnt_reg + 5'h01 : 5'h00;
    end
  end
  // Table waits; prohibited codes act as the longest
  function automatic int waits(input logic [3:0] c);
    case (c)
      4'h7: return 8;
      4'h8: return 10;
      4'h9: return 12;
      4'hA: return 14;
      4'hB: return 18;
      default: return (c < 4'h7) ? int'(c) : 24;
    endcase
  endfunction
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  chk_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside read");
  chk_rsvd_zero: assert property ($past(reg_read_i) && $past(reg_addr_i) == 8'h00
    |-> (reg_rdata_o & 32'hFFEFF83F) == 32'h0) else $error("reserved bits not zero");
  chk_idle_pins: assert property (!access_busy_o |-> &byte_enable_n_o && rd_wr_n_o)
    else $error("pins active while idle");
  chk_lanes_only: assert property (access_busy_o |-> (~byte_enable_n_o & ~lanes_reg) == '0)
    else $error("unrequested lane enabled");
  chk_strobe_setup: assert property ($rose(access_busy_o) && !bas_reg |-> &byte_enable_n_o)
    else $error("byte enables low in setup");
  chk_status_setup: assert property ($rose(access_busy_o) && bas_reg |-> rd_wr_n_o)
    else $error("direction strobe in setup");
  chk_start_busy: assert property (access_req_i && !access_busy_o |=> access_busy_o)
    else $error("access not started");
  chk_done_pulse: assert property (access_done_o == $fell(access_busy_o))
    else $error("done not at end of access");
  chk_wait_count: assert property (access_done_o && mask_reg
    |-> int'(cnt_reg) == waits(code_reg) + 3) else $error("wrong access length");
  cover property ($rose(access_busy_o) && bas_reg);
  cover property (access_done_o && !mask_reg);
  cover property (!ext_wait_n_i && access_busy_o);
endmodule
bind area3_wait_control area3_chk #(.LANES(LANES)) u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .access_req_i(access_req_i), .access_busy_o(access_busy_o),
  .access_done_o(access_done_o), .ext_wait_n_i(ext_wait_n_i),
  .access_lanes_i(access_lanes_i), .byte_enable_n_o(byte_enable_n_o), .rd_wr_n_o(rd_wr_n_o));
`default_nettype wire

//--- verification/sram_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Slow memory on the far side
// ****
module sram_partner (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic [3:0] be_n_i,      // Byte enables from the block
  input  wire logic [4:0] stall_i,     // Wait length per access, 0 = prompt
  output var  logic       ext_wait_n_o // Wait pin, pulled high when idle
);
  logic [4:0] cnt_reg;  // Wait cycles still to show
  logic       seen_reg; // Enables were low last cycle
  // Start the wait once per access at the first enabled cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_reg <= 5'h00;
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= ~&be_n_i;
      if (~&be_n_i && !seen_reg) cnt_reg <= stall_i;
      else if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
    end
  end
  assign ext_wait_n_o = (cnt_reg == 5'h00);
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb_top;
  import area3_wait_pkg::*;
  logic        core_clk_i, reset_i, reg_write_i, reg_read_i, access_req_i, access_write_i;
  logic        access_busy_o, access_done_o, ext_wait_n_i, rd_wr_n_o;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [3:0]  access_lanes_i, byte_enable_n_o;
  logic [4:0]  stall;
  int          failures, compares;
  area3_wait_control #(.LANES(4)) dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .access_req_i(access_req_i),
    .access_write_i(access_write_i), .access_lanes_i(access_lanes_i),
    .access_busy_o(access_busy_o), .access_done_o(access_done_o), .ext_wait_n_i(ext_wait_n_i),
    .byte_enable_n_o(byte_enable_n_o), .rd_wr_n_o(rd_wr_n_o));
  sram_partner mem (.core_clk_i(core_clk_i), .reset_i(reset_i), .be_n_i(byte_enable_n_o),
    .stall_i(stall), .ext_wait_n_o(ext_wait_n_i));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_int(input string n, input int e, input int g);
    compares++;
    if (g != e) begin
      failures++;
      $display("[ERR] %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // One access on lanes 0 and 2; counts cycles up to and with done
  task automatic access(input logic wr, output int lat, output int be, output int rw);
    @(posedge core_clk_i);
    access_req_i <= 1'b1;
    access_write_i <= wr;
    access_lanes_i <= 4'h5;
    @(posedge core_clk_i);
    access_req_i <= 1'b0;
    lat = 0;
    be = 0;
    rw = 0;
    repeat (100) begin
      #1 lat++;
      if (byte_enable_n_o !== 4'hF) be++;
      if (rd_wr_n_o !== 1'b1) rw++;
      if (access_done_o === 1'b1) return;
      @(posedge core_clk_i);
    end
    failures++;
    finish_test();
  endtask
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(AREA3_WAIT_CONTROL_OFF, d);
    chk_word("ctrl reset", 32'h00000500, d);
    reg_rd(8'h08, d);
    chk_word("unmapped", 32'h00000000, d);
    reg_rd(AREA3_WAIT_STATUS_OFF, d);
    chk_word("status idle", 32'h00000000, d);
    reg_wr(AREA3_WAIT_CONTROL_OFF, 32'h00100640);
    reg_wr(AREA3_WAIT_STATUS_OFF, 32'h00000000);
    reg_rd(AREA3_WAIT_CONTROL_OFF, d);
    chk_word("ctrl rw", 32'h00100640, d);
  endtask
  // Every legal code, wait pin active but masked
  task automatic t_table();
    int w[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
    int lat, be, rw;
    for (int c = 0; c < 13; c++) begin
      reg_wr(AREA3_WAIT_CONTROL_OFF, (32'(c) << READ_WAIT_LSB) | 32'h40);
      access(1'b1, lat, be, rw);
      chk_int("latency", w[c] + 4, lat);
      chk_int("strobe", w[c] + 1, be);
      chk_int("status", w[c] + 3, rw);
    end
  endtask
  task automatic t_bas();
    int lat, be, rw;
    reg_wr(AREA3_WAIT_CONTROL_OFF, 32'h00100140);
    access(1'b1, lat, be, rw);
    chk_int("bas status", 5, be);
    chk_int("bas strobe", 3, rw);
    access(1'b0, lat, be, rw);
    chk_int("bas read dir", 0, rw);
    chk_int("bas read status", 5, be);
    chk_int("bas read latency", 6, lat);
  endtask
  // Zero programmed wait; the first access wakes the memory's wait pin,
  // the second one meets it already synchronised at its strobe
  task automatic t_mask();
    int lat, be, rw;
    stall <= 5'h06;
    reg_wr(AREA3_WAIT_CONTROL_OFF, 32'h00000000);
    access(1'b1, lat, be, rw);
    access(1'b1, lat, be, rw);
    chk_int("wait honoured", 1, int'(lat > 4));
    reg_wr(AREA3_WAIT_CONTROL_OFF, 32'h00000040);
    access(1'b1, lat, be, rw);
    access(1'b1, lat, be, rw);
    chk_int("wait ignored", 4, lat);
  endtask
  initial begin
    {reset_i, reg_write_i, reg_read_i, access_req_i, access_write_i} = 5'b10000;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    access_lanes_i = 4'h0;
    stall = 5'h03;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_table();
    t_bas();
    t_mask();
    finish_test();
  end
endmodule
`default_nettype wire

//--- verilog/area3_wait_control.sv
`timescale 1ns/1ps
`default_nettype none

module area3_wait_control
  import area3_wait_pkg::*;
#(
  parameter int LANES = 4 // Byte lanes on the external bus
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  // Register port
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_write_i,
  input  wire logic             reg_read_i,
  output var  logic [31:0]      reg_rdata_o,
  // Access request from the bus controller core
  input  wire logic             access_req_i,
  input  wire logic             access_write_i,
  input  wire logic [LANES-1:0] access_lanes_i,
  output var  logic             access_busy_o,
  output var  logic             access_done_o,
  // External memory pins
  input  wire logic             ext_wait_n_i,
  output var  logic [LANES-1:0] byte_enable_n_o,
  output var  logic             rd_wr_n_o
);

  // ************************************************
  // Helper functions
  // ************************************************

  // Nonlinear read wait table; prohibited codes fall back to the longest wait
  function automatic logic [WAIT_CNT_W-1:0] wait_cycles(input logic [3:0] code);
    logic [WAIT_CNT_W-1:0] cyc;
    cyc = WAIT_MAX_CYCLES;
    unique case (code)
      4'h0, 4'h1, 4'h2, 4'h3,
      4'h4, 4'h5, 4'h6: cyc = {1'b0, code};
      4'h7:             cyc = 5'h08;
      4'h8:             cyc = 5'h0A;
      4'h9:             cyc = 5'h0C;
      4'hA:             cyc = 5'h0E;
      4'hB:             cyc = 5'h12;
      4'hC:             cyc = 5'h18;
      default:          cyc = WAIT_MAX_CYCLES;  // Codes 1101 to 1111, prohibited but stored as written
    endcase
    return cyc;
  endfunction

  // Assembles the visible control word; unstored bits come back as zero
  function automatic logic [31:0] control_word(input logic       byte_access_select,
                                               input logic [3:0] wr,
                                               input logic       wm);
    logic [31:0] w;
    w = 32'h0000_0000;                                 // Reserved bits read zero
    w[BYTE_ACCESS_SELECT_BIT]          = byte_access_select;
    w[READ_WAIT_MSB:READ_WAIT_LSB]     = wr;
    w[EXT_WAIT_MASK_BIT]               = wm;
    return w;
  endfunction

  // ************************************************
  // Storage
  // ************************************************
  logic                  byte_access_select_reg;  // Strobe/status choice
  logic                  byte_access_select_next;
  logic [3:0]            read_wait_reg;           // Read wait code
  logic [3:0]            read_wait_next;
  logic                  ext_wait_mask_reg;       // Ignore external wait when set
  logic                  ext_wait_mask_next;
  logic [31:0]           rdata_reg;               // Read data, valid one cycle
  logic [31:0]           rdata_next;

  access_state_e         state_reg;               // Access sequencer
  access_state_e         state_next;
  logic [WAIT_CNT_W-1:0] count_reg;               // Remaining programmed waits
  logic [WAIT_CNT_W-1:0] count_next;
  logic                  write_reg;               // Current access is a write
  logic                  write_next;
  logic [LANES-1:0]      lanes_reg;               // Lanes of the current access
  logic [LANES-1:0]      lanes_next;

  logic [LANES-1:0]      byte_enable_n_reg;       // Pin drivers
  logic [LANES-1:0]      byte_enable_n_next;
  logic                  rd_wr_n_reg;
  logic                  rd_wr_n_next;
  logic                  busy_reg;
  logic                  busy_next;
  logic                  done_reg;
  logic                  done_next;

  logic                  wait_meta_reg;           // Synchroniser first stage
  logic                  wait_sync_reg;           // Synchroniser second stage

  logic                  ext_stall;               // External wait in force
  logic                  strobe_phase;            // Next state lies in the strobe window
  logic                  status_phase;            // Next state lies inside the access

  // ************************************************
  // External wait synchroniser
  // ************************************************

  // The pin is asynchronous to the core clock; only the second stage is used
  // Reset loads the idle level of the inverted pin, so no false stall follows
  // reset. The price is two cycles of latency before a stall takes hold.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wait_meta_reg <= 1'b0;
      wait_sync_reg <= 1'b0;
    end else begin
      wait_meta_reg <= ~ext_wait_n_i;
      wait_sync_reg <= wait_meta_reg;
    end
  end

  // Mask bit gates the pin for the sequencer only, status still shows it; clear means honour it
  assign ext_stall = wait_sync_reg & ~ext_wait_mask_reg;

  // ************************************************
  // Register port
  // ************************************************

  // Reads are registered so software timing does not depend on decode depth;
  // the data stand for exactly one cycle and read back as zero afterwards.
  // Writes store only the defined fields, so stray reserved bits are dropped
  always_comb begin
    byte_access_select_next = byte_access_select_reg;
    read_wait_next          = read_wait_reg;
    ext_wait_mask_next      = ext_wait_mask_reg;
    rdata_next              = 32'h0000_0000;
    if (reg_write_i && reg_addr_i == AREA3_WAIT_CONTROL_OFF) begin
      byte_access_select_next = reg_wdata_i[BYTE_ACCESS_SELECT_BIT];
      read_wait_next          = reg_wdata_i[READ_WAIT_MSB:READ_WAIT_LSB];
      ext_wait_mask_next      = reg_wdata_i[EXT_WAIT_MASK_BIT];
    end
    if (reg_read_i) begin
      unique case (reg_addr_i)
        AREA3_WAIT_CONTROL_OFF: begin
          // Only stored fields appear
          rdata_next = control_word(byte_access_select_reg, read_wait_reg,
                                    ext_wait_mask_reg);
        end
        AREA3_WAIT_STATUS_OFF: begin
          rdata_next[STAT_BUSY_BIT]                             = busy_reg;
          rdata_next[STAT_EXT_WAIT_BIT]                         = wait_sync_reg;
          rdata_next[STAT_COUNT_LSB +: WAIT_CNT_W]              = count_reg;
        end
        default: begin
          // Unmapped address reads zero
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register storage; reset loads a fourteen-cycle wait (code 1010) with both bits clear
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      byte_access_select_reg <= BYTE_ACCESS_SELECT_RST;
      read_wait_reg          <= READ_WAIT_RST;
      ext_wait_mask_reg      <= EXT_WAIT_MASK_RST;
      rdata_reg              <= 32'h0000_0000;
    end else begin
      byte_access_select_reg <= byte_access_select_next;
      read_wait_reg          <= read_wait_next;
      ext_wait_mask_reg      <= ext_wait_mask_next;
      rdata_reg              <= rdata_next;
    end
  end

  // ************************************************
  // Access sequencer
  // ************************************************

  // Timeline of one access, counted in core clock cycles after the taking edge:
  //   1        setup, address and direction settle before any strobe
  //   2..N+1   programmed waits from the read wait table
  //   N+2      final strobe cycle, stretched while the external wait holds
  //   N+3      hold, strobes released, busy still high
  //   N+4      done pulses and a new request may be taken in that cycle
  // The external wait passes a two-stage synchroniser, so a memory must pull
  // its pin low at least two cycles before the final strobe cycle to stretch
  // it. A memory that only reacts to the first byte enable is too late for a
  // zero-wait access; its wait then lands on the following access instead.
  //
  // Setup, programmed waits, strobe with external stretch, then hold.
  // Waits are loaded at setup, so a rewrite mid-access affects the next one.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    write_next = write_reg;
    lanes_next = lanes_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        // Requests are taken only here; others are ignored while busy
        if (access_req_i) begin
          write_next = access_write_i;
          lanes_next = access_lanes_i;
          count_next = wait_cycles(read_wait_reg);
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Zero programmed waits skip straight to the strobe
        if (count_reg == '0) begin
          state_next = ST_STROBE;
        end else begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // One cycle per programmed wait
        count_next = count_reg - 5'h01;
        if (count_reg == 5'h01) begin
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // External wait stretches the strobe even after zero waits
        if (!ext_stall) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Access ends; done pulses together with the return to idle
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Window decode on the next state keeps the pin outputs flop-driven
  assign strobe_phase = (state_next == ST_WAIT) || (state_next == ST_STROBE);
  assign status_phase = strobe_phase || (state_next == ST_SETUP) ||
                        (state_next == ST_HOLD);

  // ************************************************
  // Pin timing
  // ************************************************

  // Select clear: byte enables strobe, direction low over the whole write.
  // Select set: byte enables low over the whole access, direction strobes.
  // Decoding from the next state costs a wide comparator ahead of each pin
  // flop, but keeps every pin glitch-free and aligned to the same clock edge.
  // Reads never drive the direction low, whichever mode is selected.
  always_comb begin
    byte_enable_n_next = '1;
    rd_wr_n_next       = 1'b1;
    busy_next          = status_phase;
    if (!byte_access_select_reg) begin
      if (strobe_phase) begin
        byte_enable_n_next = ~lanes_next;
      end
      if (status_phase && write_next) begin
        rd_wr_n_next = 1'b0;
      end
    end else begin
      if (status_phase) begin
        byte_enable_n_next = ~lanes_next;
      end
      if (strobe_phase && write_next) begin
        rd_wr_n_next = 1'b0;
      end
    end
  end

  // Sequencer and pin registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg         <= ST_IDLE;
      count_reg         <= '0;
      write_reg         <= 1'b0;
      lanes_reg         <= '0;
      byte_enable_n_reg <= '1;
      rd_wr_n_reg       <= 1'b1;
      busy_reg          <= 1'b0;
      done_reg          <= 1'b0;
    end else begin
      state_reg         <= state_next;
      count_reg         <= count_next;
      write_reg         <= write_next;
      lanes_reg         <= lanes_next;
      byte_enable_n_reg <= byte_enable_n_next;
      rd_wr_n_reg       <= rd_wr_n_next;
      busy_reg          <= busy_next;
      done_reg          <= done_next;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  // Every output is a plain copy of a flop; no logic sits between them.
  assign reg_rdata_o     = rdata_reg;
  assign access_busy_o   = busy_reg;
  assign access_done_o   = done_reg;
  assign byte_enable_n_o = byte_enable_n_reg;
  assign rd_wr_n_o       = rd_wr_n_reg;

endmodule

`default_nettype wire

//--- verilog/area3_wait_pkg.sv
`default_nettype none

package area3_wait_pkg;

  // ************************************************
  // Register map
  // ************************************************
  localparam logic [7:0]  AREA3_WAIT_CONTROL_OFF = 8'h00; // Wait control word
  localparam logic [7:0]  AREA3_WAIT_STATUS_OFF  = 8'h04; // Sequencer status word

  // ************************************************
  // Wait control fields
  // ************************************************
  localparam int          BYTE_ACCESS_SELECT_BIT = 20;
  localparam int          READ_WAIT_LSB          = 7;
  localparam int          READ_WAIT_MSB          = 10;
  localparam int          EXT_WAIT_MASK_BIT      = 6;

  // ************************************************
  // Status fields
  // ************************************************
  localparam int          STAT_BUSY_BIT          = 0;
  localparam int          STAT_EXT_WAIT_BIT      = 1;
  localparam int          STAT_COUNT_LSB         = 8;

  // ************************************************
  // Reset values
  // ************************************************
  localparam logic        BYTE_ACCESS_SELECT_RST = 1'b0;
  localparam logic [3:0]  READ_WAIT_RST          = 4'hA;
  localparam logic        EXT_WAIT_MASK_RST      = 1'b0;

  // ************************************************
  // Timing
  // ************************************************
  localparam int          WAIT_CNT_W             = 5;     // Holds the largest wait of 24
  localparam logic [4:0]  WAIT_MAX_CYCLES        = 5'h18; // Used for prohibited codes too

  // One-hot access sequencer states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_WAIT   = 5'b00100,
    ST_STROBE = 5'b01000,
    ST_HOLD   = 5'b10000
  } access_state_e;

endpackage

`default_nettype wire
